/* File: txofp_pkg.sv */
// constants, types and state layout for the transmit output formatter
// How it works
// - the 3-bit slice select routes that slice's test data to the test output
// - test clock period, high plus low, is one plus test rate cycles; rate 0 holds it high
// - a 2-bit code picks output width 18, 16, 14 or 12 bits
// - rounded words sit MSB-justified on 18 pins, unused low pins zero
// - a 4-bit enable, reset all ones, gates each bus; disabled buses stay zero
// - the interleave bit alternates I and Q samples on each bus
// - the real bit, reset one, selects real output; cleared means complex I/Q
// - each sum chain is scaled by two to its own 4-bit scale field
// - scaled samples round to the width then saturate, never wrap
// - meter squares I and Q separately and accumulates; one pair is one step
// - the step count joins bits 0-15 from low and 16-20 from high register
// - accumulation starts after sync plus delay, and at each interval restart
// - reaching the count publishes the result and sets the meter's interrupt status bit
// - the 9-bit start delay counts in units of eight output samples
// - a 4-bit mask, one bit per meter, gates the meter interrupts
package txofp_pkg;

  localparam int SMP_W    = 18;
  localparam int NCH      = 4;
  localparam int NSLC     = 8;
  localparam int CNT_W    = 21;
  localparam int HI_W     = 5;
  localparam int DLY_W    = 9;
  localparam int DCNT_W   = 12;
  localparam int RATE_W   = 5;
  localparam int ACC_W    = 64;
  localparam int EXT_W    = 40;
  localparam int RND_STEP = 2;
  localparam int DLY_UNIT = 8;
  localparam int NMTR     = 4;

  // register indices on the plain port
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_GAIN = 8'h01;
  localparam logic [7:0] ADR_CNTL = 8'h02;
  localparam logic [7:0] ADR_CNTH = 8'h03;
  localparam logic [7:0] ADR_IVLL = 8'h04;
  localparam logic [7:0] ADR_TCLK = 8'h05;
  localparam logic [7:0] ADR_RES0 = 8'h08;
  localparam logic [7:0] ADR_RES1 = 8'h09;
  localparam logic [7:0] ADR_RES2 = 8'h0A;
  localparam logic [7:0] ADR_RES3 = 8'h0B;
  localparam logic [7:0] ADR_IST  = 8'h0C;
  localparam logic [7:0] ADR_IEN  = 8'h0D;
  localparam logic [7:0] ADR_ICLR = 8'h0E;

  // field positions
  localparam int CTRL_SLICE_LSB = 13;
  localparam int CTRL_RND_LSB   = 8;
  localparam int CTRL_ENA_LSB   = 4;
  localparam int CTRL_INTL_BIT  = 1;
  localparam int CTRL_REAL_BIT  = 0;
  localparam int CNTH_DLY_LSB   = 7;
  localparam int TCLK_RATE_LSB  = 11;

  // reset values
  localparam logic [3:0] ENA_RST  = 4'hF;
  localparam logic       REAL_RST = 1'b1;
  localparam logic [1:0] RND_18   = 2'b00;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_ACCUM = 2'b10,
    ST_HOLD  = 2'b11
  } txofp_mstate_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } txofp_req_s;

  typedef logic [NCH-1:0][SMP_W-1:0]  txofp_bus_t;
  typedef logic [NSLC-1:0][SMP_W-1:0] txofp_slice_t;

  typedef struct packed {
    logic [2:0]         slice;
    logic [1:0]         rnd;
    logic [NCH-1:0]     ena;
    logic               interl;
    logic               real_m;
    logic [NCH-1:0][3:0] scale;
    logic [15:0]        cnt_lo;
    logic [HI_W-1:0]    cnt_hi;
    logic [DLY_W-1:0]   dly;
    logic [15:0]        ivl_lo;
    logic [HI_W-1:0]    ivl_hi;
    logic [RATE_W-1:0]  rate;
    logic [NMTR-1:0]    irq_en;
    logic [NMTR-1:0]    irq_st;
    logic               irq;
    txofp_mstate_e      mst;
    logic [DCNT_W-1:0]  dcnt;
    logic [CNT_W-1:0]   step;
    logic [CNT_W-1:0]   icnt;
    logic [ACC_W-1:0]   acc;
    logic [ACC_W-1:0]   res;
    txofp_bus_t         bus;
    logic               iflag;
    logic               phase;
    logic [RATE_W-1:0]  tcnt;
    logic               tclk;
    logic [SMP_W-1:0]   tst;
    logic [15:0]        rdata;
  } txofp_state_s;

endpackage

/* File: txofp_top.sv */
// transmit output formatter with composite power meter 0
`timescale 1ns/10ps
module txofp_top (
  // clock, reset, freeze
  input  logic                    sys_clk_i,
  input  logic                    srst_i,
  input  logic                    ce_i,
  // register port
  input  txofp_pkg::txofp_req_s   req_i,
  output logic [15:0]             rdata_o,
  // sum chain streams and sync
  input  logic                    sample_vld_i,
  input  txofp_pkg::txofp_bus_t   sum_i_i,
  input  txofp_pkg::txofp_bus_t   sum_q_i,
  input  logic                    sync_i,
  // test observation
  input  txofp_pkg::txofp_slice_t tst_slice_data_i,
  output logic [17:0]             tst_data_o,
  output logic                    tst_clk_o,
  // output buses and interrupt
  output txofp_pkg::txofp_bus_t   tx_bus_o,
  output logic                    tx_iflag_o,
  output logic                    irq_o
);
  import txofp_pkg::*;

  txofp_state_s q;
  txofp_state_s d;

  txofp_bus_t                fi;
  txofp_bus_t                fq;
  logic signed [SMP_W-1:0]   pi;
  logic signed [SMP_W-1:0]   pq;
  logic [2*SMP_W-1:0]        sqi;
  logic [2*SMP_W-1:0]        sqq;
  logic [ACC_W-1:0]          pwr;
  logic [CNT_W-1:0]          cnt;
  logic [CNT_W-1:0]          ivl;
  logic [NMTR-1:0]           clr;
  logic [NMTR-1:0]           set;
  logic                      done;
  logic                      rstrt;

  // scale, round with half-up, saturate, then MSB-justify
  function automatic logic [SMP_W-1:0] fmt(input logic [SMP_W-1:0] x,
                                           input logic [3:0]       s,
                                           input logic [1:0]       rc);
    logic signed [EXT_W-1:0] v;
    logic signed [EXT_W-1:0] mx;
    int                      dr;
    dr = RND_STEP * int'(rc);
    v  = EXT_W'(signed'(x)) <<< s;
    if (dr != 0) begin
      v = v + (EXT_W'(1) <<< (dr - 1));
    end
    v  = v >>> dr;
    mx = (EXT_W'(1) <<< (SMP_W - 1 - dr)) - EXT_W'(1);
    if (v > mx) begin
      v = mx;
    end else if (v < -mx - EXT_W'(1)) begin
      v = -mx - EXT_W'(1);
    end
    return SMP_W'(v <<< dr);
  endfunction

  always_comb begin
    d     = q;
    d.rdata = '0;
    clr   = '0;
    set   = '0;
    done  = 1'b0;
    rstrt = 1'b0;
    cnt   = {q.cnt_hi, q.cnt_lo};
    ivl   = {q.ivl_hi, q.ivl_lo};
    for (int k = 0; k < NCH; k++) begin
      fi[k] = fmt(sum_i_i[k], q.scale[k], q.rnd);
      fq[k] = fmt(sum_q_i[k], q.scale[k], q.rnd);
    end
    // meter sees the scaled, limited signal at full width
    pi  = signed'(fmt(sum_i_i[0], q.scale[0], RND_18));
    pq  = signed'(fmt(sum_q_i[0], q.scale[0], RND_18));
    sqi = pi * pi;
    sqq = pq * pq;
    pwr = ACC_W'(sqi) + ACC_W'(sqq);

    // register writes
    if (req_i.wr) begin
      case (req_i.addr)
        ADR_CTRL: begin
          d.slice  = req_i.wdata[CTRL_SLICE_LSB +: 3];
          d.rnd    = req_i.wdata[CTRL_RND_LSB +: 2];
          d.ena    = req_i.wdata[CTRL_ENA_LSB +: NCH];
          d.interl = req_i.wdata[CTRL_INTL_BIT];
          d.real_m = req_i.wdata[CTRL_REAL_BIT];
        end
        ADR_GAIN: d.scale  = req_i.wdata;
        ADR_CNTL: d.cnt_lo = req_i.wdata;
        ADR_CNTH: begin
          d.cnt_hi = req_i.wdata[HI_W-1:0];
          d.dly    = req_i.wdata[CNTH_DLY_LSB +: DLY_W];
        end
        ADR_IVLL: d.ivl_lo = req_i.wdata;
        ADR_TCLK: begin
          d.ivl_hi = req_i.wdata[HI_W-1:0];
          d.rate   = req_i.wdata[TCLK_RATE_LSB +: RATE_W];
        end
        ADR_IEN:  d.irq_en = req_i.wdata[NMTR-1:0];
        ADR_ICLR: clr      = req_i.wdata[NMTR-1:0];
        default: begin
        end
      endcase
    end

    // register reads, answered in the next cycle only
    if (req_i.rd) begin
      case (req_i.addr)
        ADR_CTRL: begin
          d.rdata[CTRL_SLICE_LSB +: 3]  = q.slice;
          d.rdata[CTRL_RND_LSB +: 2]    = q.rnd;
          d.rdata[CTRL_ENA_LSB +: NCH]  = q.ena;
          d.rdata[CTRL_INTL_BIT]        = q.interl;
          d.rdata[CTRL_REAL_BIT]        = q.real_m;
        end
        ADR_GAIN: d.rdata = q.scale;
        ADR_CNTL: d.rdata = q.cnt_lo;
        ADR_CNTH: begin
          d.rdata[HI_W-1:0]              = q.cnt_hi;
          d.rdata[CNTH_DLY_LSB +: DLY_W] = q.dly;
        end
        ADR_IVLL: d.rdata = q.ivl_lo;
        ADR_TCLK: begin
          d.rdata[HI_W-1:0]                = q.ivl_hi;
          d.rdata[TCLK_RATE_LSB +: RATE_W] = q.rate;
        end
        ADR_RES0: d.rdata = q.res[15:0];
        ADR_RES1: d.rdata = q.res[31:16];
        ADR_RES2: d.rdata = q.res[47:32];
        ADR_RES3: d.rdata = q.res[63:48];
        ADR_IST:  d.rdata[NMTR-1:0] = q.irq_st;
        ADR_IEN:  d.rdata[NMTR-1:0] = q.irq_en;
        default:  d.rdata = '0;
      endcase
    end

    // power meter sequencing, one step per I/Q sample pair
    if (sample_vld_i) begin
      case (q.mst)
        ST_IDLE: begin
        end
        ST_DELAY: begin
          d.dcnt = q.dcnt - DCNT_W'(1);
          if (q.dcnt == DCNT_W'(1)) begin
            d.mst  = ST_ACCUM;
            d.acc  = '0;
            d.step = '0;
            d.icnt = '0;
          end
        end
        ST_ACCUM: begin
          d.acc  = q.acc + pwr;
          d.step = q.step + CNT_W'(1);
          // a zero count behaves as a single step
          if (CNT_W'(q.step + CNT_W'(1)) >= cnt) begin
            done  = 1'b1;
            d.res = q.acc + pwr;
            d.mst = ST_HOLD;
            set[0] = 1'b1;
          end
        end
        ST_HOLD: begin
        end
        default: d.mst = ST_IDLE;
      endcase
      if (q.mst == ST_ACCUM || q.mst == ST_HOLD) begin
        d.icnt = q.icnt + CNT_W'(1);
        // zero interval means one measurement per sync
        if (ivl != '0 && CNT_W'(q.icnt + CNT_W'(1)) == ivl) begin
          rstrt  = 1'b1;
          d.mst  = ST_ACCUM;
          d.acc  = '0;
          d.step = '0;
          d.icnt = '0;
        end
      end
    end

    // sync restarts the delay from any state
    if (sync_i) begin
      d.dcnt = DCNT_W'(q.dly) * DCNT_W'(DLY_UNIT);
      d.acc  = '0;
      d.step = '0;
      d.icnt = '0;
      d.mst  = (q.dly == '0) ? ST_ACCUM : ST_DELAY;
    end

    // set wins over a clear in the same cycle
    d.irq_st = (q.irq_st & ~clr) | set;
    d.irq    = |(d.irq_st & d.irq_en);

    // output buses update once per sample
    if (sample_vld_i) begin
      d.phase = q.interl ? ~q.phase : 1'b0;
      d.iflag = q.interl ? ~q.phase : 1'b1;
      for (int k = 0; k < NCH; k++) begin
        if (!q.ena[k]) begin
          d.bus[k] = '0;
        end else if (q.interl) begin
          d.bus[k] = q.phase ? fq[k] : fi[k];
        end else if (q.real_m) begin
          d.bus[k] = fi[k];
        end else begin
          // complex pairs buses: even bus I, odd bus Q of chain k/2
          d.bus[k] = k[0] ? fq[k/2] : fi[k/2];
        end
      end
    end

    // test clock: a flop cannot show a true full-rate clock, so rate 0 is
    // held high
    d.tcnt = (q.tcnt >= q.rate) ? '0 : q.tcnt + RATE_W'(1);
    d.tclk = (d.tcnt <= (q.rate >> 1));
    d.tst  = tst_slice_data_i[q.slice];
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      q        <= '0;
      q.ena    <= ENA_RST;
      q.real_m <= REAL_RST;
      q.iflag  <= 1'b1;
      q.tclk   <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign rdata_o    = q.rdata;
  assign tst_data_o = q.tst;
  assign tst_clk_o  = q.tclk;
  assign tx_bus_o   = q.bus;
  assign tx_iflag_o = q.iflag;
  assign irq_o      = q.irq;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  // low pins forced to zero for a given round code
  function automatic logic [SMP_W-1:0] lmask(input logic [1:0] rc);
    return ~({SMP_W{1'b1}} << (RND_STEP * int'(rc)));
  endfunction

  property p_slice;
    ce_i |=> tst_data_o == $past(tst_slice_data_i[q.slice]);
  endproperty
  a_slice: assert property (p_slice)
    else $error("test data not from selected slice");

  property p_tclk;
    ce_i && q.rate != '0 && q.tcnt == q.rate && $stable(q.rate)
      |=> q.tcnt == '0 && tst_clk_o;
  endproperty
  a_tclk: assert property (p_tclk)
    else $error("test clock period wrong");

  property p_lowpins;
    ce_i && sample_vld_i
      |=> (tx_bus_o[0] & lmask($past(q.rnd))) == '0;
  endproperty
  a_lowpins: assert property (p_lowpins)
    else $error("unused low output pins not zero");

  property p_disabled;
    ce_i && sample_vld_i && !q.ena[1] |=> tx_bus_o[1] == '0;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled bus not held low");

  property p_real;
    ce_i && sample_vld_i && q.real_m && !q.interl && q.ena[2]
      |=> tx_bus_o[2] == $past(fi[2]);
  endproperty
  a_real: assert property (p_real)
    else $error("real output mismatch");

  property p_interl;
    ce_i && sample_vld_i && q.interl && q.ena[0] && q.phase
      |=> tx_bus_o[0] == $past(fq[0]) && !tx_iflag_o;
  endproperty
  a_interl: assert property (p_interl)
    else $error("interleaved Q sample missing");

  property p_done;
    ce_i && done && !sync_i |=> q.irq_st[0] && q.res == $past(q.acc + pwr);
  endproperty
  a_done: assert property (p_done)
    else $error("completion not published");

  property p_hold;
    ce_i && !done |=> $stable(q.res);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result changed without completion");

  property p_mask;
    ##1 irq_o == |(q.irq_st & q.irq_en);
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt not gated by mask");

  property p_delay;
    ce_i && sync_i && q.dly == 9'h001
      |=> q.mst == ST_DELAY && q.dcnt == 12'h008;
  endproperty
  a_delay: assert property (p_delay)
    else $error("start delay not eight samples per unit");

  property p_restart;
    ce_i && rstrt && !sync_i |=> q.mst == ST_ACCUM && q.step == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("interval restart missed");

  property p_gain0;
    ce_i && sample_vld_i && q.scale[0] == '0 |-> pi == signed'(sum_i_i[0]);
  endproperty
  a_gain0: assert property (p_gain0)
    else $error("meter input not the unscaled sample");

  // only samples that cannot overflow a gain of four
  property p_gain;
    ce_i && sample_vld_i && q.real_m && !q.interl && q.ena[1] &&
      q.rnd == RND_18 && q.scale[1] == 4'h2 &&
      (&sum_i_i[1][SMP_W-1 -: 3] || !(|sum_i_i[1][SMP_W-1 -: 3]))
      |=> tx_bus_o[1] == $past(sum_i_i[1] << 2);
  endproperty
  a_gain: assert property (p_gain)
    else $error("bus gain not a power of two");

  property p_sat;
    ce_i && sample_vld_i && q.real_m && !q.interl && q.ena[2] &&
      !sum_i_i[2][SMP_W-1] && sum_i_i[2][SMP_W-2] && q.scale[2] != '0
      |=> tx_bus_o[2] == ({1'b0, {(SMP_W-1){1'b1}}} & ~lmask($past(q.rnd)));
  endproperty
  a_sat: assert property (p_sat)
    else $error("positive overflow not limited");

  property p_step;
    ce_i && sample_vld_i && q.mst == ST_ACCUM && !sync_i && !rstrt
      |=> q.step == $past(q.step) + CNT_W'(1) && q.acc >= $past(q.acc);
  endproperty
  a_step: assert property (p_step)
    else $error("sample pair not one accumulation step");

  property p_last;
    ce_i && sample_vld_i && q.mst == ST_ACCUM && cnt != '0 &&
      q.step == cnt - CNT_W'(1) |-> done;
  endproperty
  a_last: assert property (p_last)
    else $error("measurement not ended at the step count");

  property p_dlyend;
    ce_i && sample_vld_i && q.mst == ST_DELAY && q.dcnt == DCNT_W'(1) &&
      !sync_i |=> q.mst == ST_ACCUM && q.acc == '0 && q.step == '0;
  endproperty
  a_dlyend: assert property (p_dlyend)
    else $error("accumulation not started after delay");

  property p_clr;
    ce_i && req_i.wr && req_i.addr == ADR_ICLR && req_i.wdata[0] && !set[0]
      |=> !q.irq_st[0] && !irq_o;
  endproperty
  a_clr: assert property (p_clr)
    else $error("status not cleared");

  property p_rate0;
    ce_i && q.rate == '0 |=> tst_clk_o;
  endproperty
  a_rate0: assert property (p_rate0)
    else $error("rate zero test clock not high");

  c_done:    cover property (ce_i && done);
  c_restart: cover property (ce_i && rstrt);
  c_irq:     cover property (irq_o);
  c_interl:  cover property (q.interl && sample_vld_i);
  c_delay:   cover property (ce_i && q.mst == ST_DELAY && sample_vld_i);

endmodule

/* File: txofp_dac_model.sv */
// far-side converter model: counts the word sets it latches
`timescale 1ns/10ps
module txofp_dac_model (
  // clock and stream in
  input  wire logic                  sys_clk_i,
  input  wire logic                  vld_i,
  input  wire txofp_pkg::txofp_bus_t bus_i,
  // latched words
  output logic [15:0]                words_o,
  output txofp_pkg::txofp_bus_t      last_o
);
  logic        vld_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;
  // latch a cycle after the strobe, once the registered bus has settled
  always @(posedge sys_clk_i) begin
    vld_q <= vld_i;
    if (vld_q) begin
      cnt_q  <= cnt_q + 16'h0001;
      last_o <= bus_i;
    end
  end
  assign words_o = cnt_q;
endmodule

/* File: test_txofp_top.sv */
// self-checking bench for the transmit output formatter
`timescale 1ns/10ps
module test_txofp_top;
  import txofp_pkg::*;
  logic         sys_clk_i, srst_i, ce, sample_vld_i, sync_i;
  logic         tst_clk_o, tx_iflag_o, irq_o;
  txofp_req_s   req_i;
  logic [15:0]  rdata_o, words, rv;
  txofp_bus_t   sum_i_i, sum_q_i, tx_bus_o, va, vq, last;
  txofp_slice_t tst_slice_data_i;
  logic [17:0]  tst_data_o;
  logic [63:0]  res;
  int           failures, num_checks, cyc, nsmp, hi;
  int           sc[4] = '{0, 2, 4, 0};

  txofp_top u_dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce), .req_i(req_i),
    .rdata_o(rdata_o), .sample_vld_i(sample_vld_i), .sum_i_i(sum_i_i),
    .sum_q_i(sum_q_i), .sync_i(sync_i),
    .tst_slice_data_i(tst_slice_data_i), .tst_data_o(tst_data_o),
    .tst_clk_o(tst_clk_o), .tx_bus_o(tx_bus_o), .tx_iflag_o(tx_iflag_o),
    .irq_o(irq_o));

  txofp_dac_model u_dac (
    .sys_clk_i(sys_clk_i), .vld_i(sample_vld_i), .bus_i(tx_bus_o),
    .words_o(words), .last_o(last));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    req_i <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    req_i <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk_i);
    req_i <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk_i);
    req_i <= '0;
    #1 v = rdata_o;
  endtask

  task automatic rres;
    for (int j = 0; j < 4; j++) begin
      rd(ADR_RES0 + 8'(j), rv);
      res[16*j +: 16] = rv;
    end
  endtask

  task automatic smp(input txofp_bus_t i, input txofp_bus_t q);
    @(posedge sys_clk_i);
    sample_vld_i <= 1'b1;
    sum_i_i      <= i;
    sum_q_i      <= q;
    @(posedge sys_clk_i);
    sample_vld_i <= 1'b0;
    nsmp++;
    #1;
  endtask

  task automatic pulse_sync;
    @(posedge sys_clk_i);
    sync_i <= 1'b1;
    @(posedge sys_clk_i);
    sync_i <= 1'b0;
  endtask

  // scale, add half, drop 2r bits, limit, put back MSB-justified
  function automatic logic [17:0] fmt(logic [17:0] x, int s, int r);
    longint v, mx;
    int     d;
    d  = 2 * r;
    v  = longint'($signed(x)) <<< s;
    if (d > 0) v = (v + (longint'(1) <<< (d - 1))) >>> d;
    mx = (longint'(1) <<< (17 - d)) - 1;
    if (v > mx) v = mx;
    if (v < -mx - 1) v = -mx - 1;
    return 18'(v <<< d);
  endfunction

  function automatic longint pw(txofp_bus_t i, txofp_bus_t q);
    longint a, b;
    a = $signed(i[0]);
    b = $signed(q[0]);
    return 2 * (a * a + b * b);
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    srst_i = 1'b1; req_i = '0; sample_vld_i = 1'b0; sync_i = 1'b0;
    sum_i_i = '0; sum_q_i = '0;
    ce = 1'b1;
    va = {18'h20000, 18'h1FFFF, 18'h3F123, 18'h00ABC};
    vq = {18'h00007, 18'h3FFF0, 18'h00100, 18'h3FFFA};
    for (int s = 0; s < NSLC; s++) tst_slice_data_i[s] = 18'(18'h01000 + s);
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(ADR_CTRL, rv); chk(rv, 16'h00F1);
    rd(ADR_CNTL, rv); chk(rv, 16'h0000);
    rd(8'h07, rv); chk(rv, 16'h0000);
    rd(ADR_ICLR, rv); chk(rv, 16'h0000);
    chk({tx_iflag_o, tst_clk_o, irq_o}, 3'b110);
    // a write while frozen must not land
    @(posedge sys_clk_i);
    ce <= 1'b0;
    wr(ADR_GAIN, 16'h1234);
    ce <= 1'b1;
    rd(ADR_GAIN, rv); chk(rv, 16'h0000);
    $display("test reset values done");
    wr(ADR_GAIN, 16'h0420);
    rd(ADR_GAIN, rv); chk(rv, 16'h0420);
    for (int r = 0; r < 4; r++) begin
      wr(ADR_CTRL, 16'h00F1 | 16'(r << 8));
      smp(va, vq);
      for (int k = 0; k < 4; k++) chk(tx_bus_o[k], fmt(va[k], sc[k], r));
    end
    $display("test scale and round done");
    wr(ADR_GAIN, 16'h0000);
    wr(ADR_CTRL, 16'h0051);
    smp(va, vq);
    for (int k = 0; k < 4; k++) chk(tx_bus_o[k], k % 2 ? 18'h0 : va[k]);
    wr(ADR_CTRL, 16'h00F0);
    smp(va, vq);
    for (int k = 0; k < 4; k++) chk(tx_bus_o[k], k % 2 ? vq[k/2] : va[k/2]);
    wr(ADR_CTRL, 16'h00F2);
    for (int p = 0; p < 2; p++) begin
      smp(va, vq);
      chk(tx_iflag_o, p == 0);
      for (int k = 0; k < 4; k++) chk(tx_bus_o[k], p ? vq[k] : va[k]);
    end
    $display("test bus modes done");
    wr(ADR_CTRL, 16'h00F1);
    wr(ADR_CNTL, 16'h0002);
    wr(ADR_IEN, 16'h0001);
    pulse_sync();
    smp(va, vq);
    smp(va, vq);
    @(posedge sys_clk_i);
    #1 chk(irq_o, 1'b1);
    rres(); chk(res, pw(va, vq));
    rd(ADR_IST, rv); chk(rv, 16'h0001);
    wr(ADR_ICLR, 16'h0001);
    @(posedge sys_clk_i);
    #1 chk(irq_o, 1'b0);
    wr(ADR_IEN, 16'h0000);
    wr(ADR_CNTH, 16'h0080);
    pulse_sync();
    for (int k = 0; k < 10; k++) begin
      if (k < 8) smp(va, va);
      else smp(vq, vq);
      if (k == 8) begin
        rres(); chk(res, pw(va, vq));
      end
    end
    @(posedge sys_clk_i);
    #1 chk(irq_o, 1'b0);
    rd(ADR_IST, rv); chk(rv, 16'h0001);
    rres(); chk(res, pw(vq, vq));
    wr(ADR_CNTH, 16'h0000);
    wr(ADR_IVLL, 16'h0003);
    pulse_sync();
    // third pair lands in the hold, then the interval restarts the sum
    for (int k = 0; k < 5; k++) begin
      if (k < 3) smp(va, va);
      else smp(vq, vq);
    end
    rres(); chk(res, pw(vq, vq));
    wr(ADR_IVLL, 16'h0000);
    $display("test power meter done");
    for (int t = 0; t < 2; t++) begin
      wr(ADR_TCLK, t ? 16'h2000 : 16'h1800);
      repeat (4) @(posedge sys_clk_i);
      hi = 0;
      repeat (t ? 20 : 16) begin
        @(posedge sys_clk_i);
        #1 hi += int'(tst_clk_o);
      end
      chk(hi, t ? 12 : 8);
    end
    for (int s = 0; s < NSLC; s++) begin
      wr(ADR_CTRL, {3'(s), 13'h00F1});
      repeat (2) @(posedge sys_clk_i);
      #1 chk(tst_data_o, 18'(18'h01000 + s));
    end
    $display("test observation done");
    for (int k = 0; k < 4; k++) chk(last[k], vq[k]);
    chk(words, nsmp);
    test_done();
  end
endmodule
